// ==== asf_pkg.sv ====
// Purpose: shared constants and types for the alu status flag block
// Assumes: 8-bit datapath, one clock
// Notes: register offsets are byte addresses on a 32-bit wishbone bus
package asf_pkg;
  // ==========================================================
  // flag bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned FLAG_N = 4;
  localparam logic [7:0] FLAGS_IMPL_MASK = 8'h1F;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // ==========================================================
  // register map
  localparam logic [3:0] OFS_OPA = 4'h0;
  localparam logic [3:0] OFS_OPB = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h8;
  localparam logic [3:0] OFS_RES = 4'hC;
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // command field: bits 3:0 opcode, bit 4 destination is alu_flags
  localparam int unsigned CMD_DST_BIT = 4;
  localparam int unsigned CMD_ADDR_BIT = 5;
  // ==========================================================
  // operations
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD_ACCUM_FILE = 4'h1,
    OP_ADD_LITERAL = 4'h2,
    OP_SUB_ACCUM_FILE = 4'h3,
    OP_SUB_LITERAL = 4'h4,
    OP_AND = 4'h5,
    OP_IOR = 4'h6,
    OP_XOR = 4'h7,
    OP_FILE_CLEAR = 4'h8,
    OP_ROTATE_RIGHT = 4'h9,
    OP_ROTATE_LEFT = 4'hA,
    OP_BIT_CLEAR = 4'hB,
    OP_BIT_SET = 4'hC,
    OP_NIBBLE_SWAP = 4'hD,
    OP_FILE_TO_FILE_MOVE = 4'hE,
    OP_ACCUM_TO_FILE_MOVE = 4'hF
  } asf_op_e;
  typedef struct packed {
    logic [7:0] res;
    logic [4:0] flags;
    logic [4:0] touch;
  } asf_alu_s;
endpackage : asf_pkg

// ==== asf_alu.sv ====
// Purpose: combinational 8-bit alu with flag generation
// Assumes: operand a is the file or source, b the accumulator or literal
// Notes: touch marks which flags the operation may change
`timescale 1ns/100ps
`default_nettype none
module asf_alu (
  input wire logic [3:0] op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [2:0] bit_i,
  input wire logic cin_i,
  output var asf_pkg::asf_alu_s out_o
);
  logic [4:0] lo_sum;
  logic [7:0] hi_sum;
  logic [8:0] full_sum;
  logic [7:0] addend;
  logic [7:0] augend;
  logic sub;
  always_comb begin
    sub = (op_i == asf_pkg::OP_SUB_ACCUM_FILE) || (op_i == asf_pkg::OP_SUB_LITERAL);
    // file minus accumulator; literal minus accumulator
    augend = a_i;
    addend = sub ? ~b_i : b_i;
    lo_sum = {1'b0, augend[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
    hi_sum = {1'b0, augend[6:0]} + {1'b0, addend[6:0]} + {7'h00, sub};
    full_sum = {1'b0, augend} + {1'b0, addend} + {8'h00, sub};
    out_o = '0;
    unique case (asf_pkg::asf_op_e'(op_i))
      asf_pkg::OP_ADD_ACCUM_FILE, asf_pkg::OP_ADD_LITERAL,
      asf_pkg::OP_SUB_ACCUM_FILE, asf_pkg::OP_SUB_LITERAL: begin
        out_o.res = full_sum[7:0];
        out_o.flags[asf_pkg::FLAG_C] = full_sum[8];
        out_o.flags[asf_pkg::FLAG_DC] = lo_sum[4];
        out_o.flags[asf_pkg::FLAG_OV] = hi_sum[7] ^ full_sum[8];
        out_o.touch = 5'h1F;
      end
      asf_pkg::OP_AND: begin
        out_o.res = a_i & b_i;
        out_o.touch = 5'h14;
      end
      asf_pkg::OP_IOR: begin
        out_o.res = a_i | b_i;
        out_o.touch = 5'h14;
      end
      asf_pkg::OP_XOR: begin
        out_o.res = a_i ^ b_i;
        out_o.touch = 5'h14;
      end
      asf_pkg::OP_FILE_CLEAR: begin
        out_o.res = 8'h00;
        out_o.touch = 5'h04;
      end
      asf_pkg::OP_ROTATE_RIGHT: begin
        out_o.res = {cin_i, a_i[7:1]};
        out_o.flags[asf_pkg::FLAG_C] = a_i[0];
        out_o.flags[asf_pkg::FLAG_DC] = a_i[4];
        out_o.touch = 5'h17;
      end
      asf_pkg::OP_ROTATE_LEFT: begin
        out_o.res = {a_i[6:0], cin_i};
        out_o.flags[asf_pkg::FLAG_C] = a_i[7];
        out_o.flags[asf_pkg::FLAG_DC] = a_i[3];
        out_o.touch = 5'h17;
      end
      // flag-neutral operations, safe for writing alu_flags
      asf_pkg::OP_BIT_CLEAR: out_o.res = a_i & ~(8'h01 << bit_i);
      asf_pkg::OP_BIT_SET: out_o.res = a_i | (8'h01 << bit_i);
      asf_pkg::OP_NIBBLE_SWAP: out_o.res = {a_i[3:0], a_i[7:4]};
      asf_pkg::OP_FILE_TO_FILE_MOVE: out_o.res = a_i;
      asf_pkg::OP_ACCUM_TO_FILE_MOVE: out_o.res = b_i;
      asf_pkg::OP_NONE: out_o.res = a_i;
    endcase
    out_o.flags[asf_pkg::FLAG_N] = out_o.res[7];
    out_o.flags[asf_pkg::FLAG_Z] = (out_o.res == 8'h00);
  end
endmodule : asf_alu
`default_nettype wire

// ==== asf_top.sv ====
// Purpose: status flag register and alu flag logic behind a wishbone slave
// Assumes: classic wishbone, 32-bit data, registers in the low byte except alu_flags, which sits in the second byte
// Notes: a command write executes one operation in the same ack edge
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - flag-changing op aimed at alu_flags loads flags, drops computed result.
// - file clear on alu_flags sets zero flag only, others unchanged.
// - upper three alu_flags bits read zero; writes ignored.
// - negative flag bit 4 copies result msb.
// - overflow flag bit 3 set when signed result sign flips.
// - zero flag bit 2 set when result is zero.
// - digit carry bit 1 is carry from low nibble on add/sub.
// - carry bit 0 is carry out of msb on add/sub.
// - subtract adds two's complement; carries are inverted borrows.
// - rotates load digit carry from bit 4/3, carry from lsb/msb.
// - alu_flags usable as source or destination of any operation.
module asf_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] alu_flags_o,
  output logic [7:0] result_o
);
  typedef struct packed {
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] cmd;
    logic [7:0] res;
    logic [7:0] flags;
    logic [31:0] dat;
    logic ack;
  } asf_state_s;

  asf_state_s st_r;
  asf_state_s st_nxt;
  asf_pkg::asf_alu_s alu_out;
  logic [7:0] src;
  logic [7:0] cmd_w;
  logic req;
  logic cmd_wr;
  logic dst_flags;

  // ==========================================================
  // byte-lane merge used for the opa and opb register writes
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel,
                                       input logic [31:0] d);
    lane0 = sel[0] ? d[7:0] : old;
  endfunction : lane0

  // ==========================================================
  // operation execute
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !st_r.ack;
    cmd_wr = req && wb_we_i && (wb_adr_i == asf_pkg::OFS_CMD) && wb_sel_i[0];
    cmd_w = wb_dat_i[7:0];
    // source may be alu_flags itself when the address bit picks it
    src = cmd_w[asf_pkg::CMD_ADDR_BIT] ? st_r.flags : st_r.opa;
    dst_flags = cmd_w[asf_pkg::CMD_DST_BIT];
  end

  asf_alu u_alu (
    .op_i(cmd_w[3:0]),
    .a_i(src),
    .b_i(st_r.opb),
    .bit_i(cmd_w[7:6] == 2'b00 ? 3'h0 : {1'b0, cmd_w[7:6]}),
    .cin_i(st_r.flags[asf_pkg::FLAG_C]),
    .out_o(alu_out)
  );

  // ==========================================================
  // state update
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req;
    st_nxt.dat = asf_pkg::UNMAPPED_RD;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        asf_pkg::OFS_OPA: st_nxt.dat = {24'h000000, st_r.opa};
        asf_pkg::OFS_OPB: st_nxt.dat = {24'h000000, st_r.opb};
        asf_pkg::OFS_CMD: st_nxt.dat = {19'h00000, st_r.flags[4:0], st_r.cmd}; 
        asf_pkg::OFS_RES: st_nxt.dat = {24'h000000, st_r.res};
        default: st_nxt.dat = asf_pkg::UNMAPPED_RD;
      endcase
    end
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        asf_pkg::OFS_OPA: st_nxt.opa = lane0(st_r.opa, wb_sel_i, wb_dat_i);
        asf_pkg::OFS_OPB: st_nxt.opb = lane0(st_r.opb, wb_sel_i, wb_dat_i);
        // direct write of alu_flags through the second byte lane
        asf_pkg::OFS_RES: if (wb_sel_i[1]) begin
          st_nxt.flags = wb_dat_i[15:8] & asf_pkg::FLAGS_IMPL_MASK;
        end
        default: ;
      endcase
    end
    if (cmd_wr) begin
      st_nxt.cmd = cmd_w;
      if (dst_flags) begin
        if (alu_out.touch != 5'h00) begin
          // result dropped; touched flags take the op's values
          st_nxt.flags[4:0] = (st_r.flags[4:0] & ~alu_out.touch)
                              | (alu_out.flags & alu_out.touch);
        end else begin
          st_nxt.flags = alu_out.res & asf_pkg::FLAGS_IMPL_MASK;
        end
      end else begin
        st_nxt.res = alu_out.res;
        st_nxt.flags[4:0] = (st_r.flags[4:0] & ~alu_out.touch)
                            | (alu_out.flags & alu_out.touch);
      end
    end
    st_nxt.flags[7:5] = 3'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.flags <= asf_pkg::FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign alu_flags_o = st_r.flags;
  assign result_o = st_r.res;

  // ==========================================================
  // checks
  sequence s_cmd_to_flags;
    cmd_wr && dst_flags && alu_out.touch != 5'h00;
  endsequence

  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) alu_flags_o[7:5] == 3'h0)
    else $error("upper flag bits not zero");
  a_flags_dest_keeps_res: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cmd_to_flags |=> $stable(result_o))
    else $error("result written when flags were destination");
  a_clear_sets_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && dst_flags && cmd_w[3:0] == 4'h8) |=> (alu_flags_o[2] &&
    alu_flags_o[4:3] == $past(alu_flags_o[4:3]) && alu_flags_o[1:0] == $past(alu_flags_o[1:0])))
    else $error("file clear on flags wrong");
  a_neg_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && alu_out.touch[4]) |=> alu_flags_o[4] == result_o[7])
    else $error("negative flag mismatch");
  a_zero_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && alu_out.touch[2]) |=> alu_flags_o[2] == (result_o == 8'h00))
    else $error("zero flag mismatch");
  a_carry_add: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && cmd_w[3:0] == 4'h1) |=>
    alu_flags_o[0] == (({1'b0, $past(src)} + {1'b0, $past(st_r.opb)}) > 9'h0FF))
    else $error("carry flag mismatch on add");
  a_borrow_sub: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && cmd_w[3:0] == 4'h3) |=>
    alu_flags_o[0] == ($past(src) >= $past(st_r.opb)))
    else $error("borrow polarity wrong");
  a_dc_add: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && cmd_w[3:0] == 4'h1) |=>
    alu_flags_o[1] == (({1'b0, $past(src[3:0])} + {1'b0, $past(st_r.opb[3:0])}) > 5'h0F))
    else $error("digit carry mismatch");
  a_ov_add: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && cmd_w[3:0] == 4'h1) |=> alu_flags_o[3] ==
    ($past(src[7]) == $past(st_r.opb[7]) && result_o[7] != $past(src[7])))
    else $error("overflow mismatch");
  a_rot_left: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && !dst_flags && cmd_w[3:0] == 4'hA) |=>
    (alu_flags_o[0] == $past(src[7]) && alu_flags_o[1] == $past(src[3])))
    else $error("rotate left carry load wrong");
  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : asf_top
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for the alu status flag block
// Assumes: ack comes one cycle after a request; flags and result settle at the ack edge
// Notes: corner cases first, then lfsr-driven operands; check compares against model, asserts also live in design
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_i, rst_i, cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] dat, rd, lf, wb_dat_o;
  logic wb_ack_o;
  logic [7:0] alu_flags_o, result_o, er;
  logic [4:0] ef;
  logic [3:0] rops [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA};
  int num_errors = 0;
  int compares = 0;
  asf_top asf_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .alu_flags_o(alu_flags_o), .result_o(result_o));
  // ==========================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    $display("unexpected at %0t: watchdog ran out", $time);
    end_sim();
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // returns {result, flags}; subtract is a plus inverted b plus one
  function automatic logic [12:0] model(input logic [3:0] o, input logic [7:0] a,
      input logic [7:0] b, input logic [1:0] ix, input logic [4:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r, bb;
    logic [4:0] n;
    logic ci;
    n = f;
    ci = (o == 4'h3 || o == 4'h4);
    bb = ci ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    r = a;
    case (o)
      4'h1, 4'h2, 4'h3, 4'h4: begin
        r = s[7:0];
        n[0] = s[8];
        n[1] = h[4];
        n[3] = s[8] ^ a[7] ^ bb[7] ^ r[7];
      end
      4'h5: r = a & b;
      4'h6: r = a | b;
      4'h7: r = a ^ b;
      4'h8: begin
        r = 8'h00;
        n[2] = 1'b1;
      end
      4'h9: begin
        r = {f[0], a[7:1]};
        n[0] = a[0];
        n[1] = a[4];
      end
      4'hA: begin
        r = {a[6:0], f[0]};
        n[0] = a[7];
        n[1] = a[3];
      end
      4'hB: r = a & ~(8'h01 << ix);
      4'hC: r = a | (8'h01 << ix);
      4'hD: r = {a[3:0], a[7:4]};
      4'hF: r = b;
      default: r = a;
    endcase
    if (o inside {[4'h1:4'h7], 4'h9, 4'hA}) begin
      n[4] = r[7];
      n[2] = (r == 8'h00);
    end
    return {r, n};
  endfunction : model
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check
  // waits for ack as long as it takes; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    #1;
    check({7'h00, wb_ack_o}, 8'h00);
  endtask : bus
  // flag-neutral ops aimed at the flags store their result there
  task automatic op(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
      input logic dst, input logic src, input logic [1:0] ix);
    logic [12:0] m;
    bus(1'b1, asf_pkg::OFS_OPA, 4'h1, {24'h0, a});
    bus(1'b1, asf_pkg::OFS_OPB, 4'h1, {24'h0, b});
    bus(1'b1, asf_pkg::OFS_CMD, 4'h1, {24'h0, ix, src, dst, o});
    m = model(o, src ? {3'b000, ef} : a, b, ix, ef);
    if (!dst) er = m[12:5];
    ef = (dst && o >= 4'hB) ? m[9:5] : m[4:0];
    check(alu_flags_o, {3'b000, ef});
    check(result_o, er);
  endtask : op
  task automatic end_sim();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dat} = '0;
    lf = 32'h66D5;
    ef = 5'h00;
    er = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(alu_flags_o, 8'h00);
    check(result_o, 8'h00);
    op(4'h1, 8'h7F, 8'h01, 1'b0, 1'b0, 2'b00);
    op(4'h2, 8'h0F, 8'h01, 1'b0, 1'b0, 2'b00);
    op(4'h1, 8'hFF, 8'h01, 1'b0, 1'b0, 2'b00);
    op(4'h3, 8'h00, 8'h01, 1'b0, 1'b0, 2'b00);
    op(4'h4, 8'h00, 8'h00, 1'b0, 1'b0, 2'b00);
    op(4'h4, 8'h80, 8'h01, 1'b0, 1'b0, 2'b00);
    op(4'h9, 8'h11, 8'h00, 1'b0, 1'b0, 2'b00);
    op(4'hA, 8'h88, 8'h00, 1'b0, 1'b0, 2'b00);
    $display("test corners done");
    repeat (60) begin
      lf = lfsr(lf);
      op(rops[lf[23:16] % 9], lf[7:0], lf[15:8], lf[24], 1'b0, 2'b00);
    end
    $display("test random done");
    bus(1'b1, asf_pkg::OFS_RES, 4'h2, 32'h0000_FF00);
    check(alu_flags_o, 8'h1F);
    bus(1'b1, asf_pkg::OFS_RES, 4'h2, 32'h0000_1B00);
    ef = 5'h1B;
    op(4'h8, 8'h55, 8'h00, 1'b1, 1'b0, 2'b00);
    for (int i = 0; i < 4; i++) begin
      op(4'hC, 8'h00, 8'h00, 1'b1, 1'b1, i[1:0]);
      op(4'hB, 8'h00, 8'h00, 1'b1, 1'b1, i[1:0]);
    end
    op(4'hD, 8'hA5, 8'h00, 1'b1, 1'b0, 2'b00);
    bus(1'b0, asf_pkg::OFS_RES, 4'h1, 32'h0);
    check(rd[7:0], er);
    bus(1'b0, asf_pkg::OFS_CMD, 4'h1, 32'h0);
    check({3'b000, rd[12:8]}, {3'b000, ef});
    $display("test flags as operand done");
    bus(1'b0, 4'h2, 4'h1, 32'h0);
    check(rd[7:0], 8'h00);
    bus(1'b1, 4'h6, 4'hF, 32'hFFFF_FFFF);
    check(alu_flags_o, {3'b000, ef});
    $display("test unmapped done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check(alu_flags_o, 8'h00);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
